// *** bench/hscfg_src.sv ***
`timescale 1ns/1ps
module hscfg_src (
    input logic clk,
    input logic [7:0] cfg_rdata,
    input logic cfg_rvalid,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata
);
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = a == 8'hf2 ? {d[7:1], 1'b0} : d;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~cfg_wdata;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        d = 8'hxx;
        repeat (4) begin
            @(posedge clk);
            if (cfg_rvalid === 1'b1) d = cfg_rdata;
        end
    endtask
endmodule // hscfg_src

// *** bench/hscfg_top_asserts.sv ***
`timescale 1ns/1ps
module hscfg_asserts #(
    parameter int STEP_CYCLES = 4
) (
    input logic clk,
    input logic srst,
    input logic cfg_wr,
    input logic cfg_rd,
    input logic [7:0] cfg_addr,
    input logic [7:0] cfg_wdata,
    input logic [7:0] cfg_rdata,
    input logic cfg_rvalid,
    input logic custom_serial_enable,
    input logic custom_text_enable,
    input logic serial_clock_strap_pin,
    input logic str_req,
    input logic [1:0] str_index,
    input logic str_valid,
    input logic str_last,
    input logic str_empty,
    input logic ss_spread_disable,
    input logic downstream_custom_charge_enable,
    input logic charge_mode_change,
    input logic port_power_control_out
);
    logic [6:0] slen, mlen, plen, want, cnt;
    logic [2:0] fld;
    logic [7:0] last_a, mask;
    int off_n, off_want;
    logic txt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    assign txt = custom_text_enable && cfg_wdata[6:0] < 7'h41;
    always_ff @(posedge clk) begin
        last_a <= cfg_addr;
        off_n <= port_power_control_out ? 0 : off_n + 1;
        if (charge_mode_change && port_power_control_out)
            off_want <= (downstream_custom_charge_enable ? fld + 1 : 1)
                * STEP_CYCLES;
        if (str_req) begin
            cnt <= 7'h00;
            want <= str_index == 2'h1 ? slen : str_index == 2'h2 ? plen
                : str_index == 2'h3 ? mlen : 7'h00;
        end else if (str_valid) cnt <= cnt + 7'h01;
        if (srst) begin
            slen <= 7'h18;
            mlen <= 7'h00;
            plen <= 7'h00;
            fld <= 3'h0;
        end else if (cfg_wr) begin
            if (cfg_addr == 8'h22 && custom_serial_enable &&
                {1'b0, cfg_wdata[5:0]} < 7'h21)
                slen <= {1'b0, cfg_wdata[5:0]};
            if (cfg_addr == 8'h23 && txt) mlen <= cfg_wdata[6:0];
            if (cfg_addr == 8'h24 && txt) plen <= cfg_wdata[6:0];
            if (cfg_addr == 8'hf2) fld <= cfg_wdata[3:1];
        end
    end
    always_comb begin
        case (last_a)
            8'h22: mask = 8'hc0;
            8'h23, 8'h24: mask = 8'h80;
            8'hf0: mask = 8'hfe;
            8'hf2: mask = 8'hf0;
            default: mask = 8'h00;
        endcase
    end
    reset_idle_a: assert property ($fell(srst) |->
        port_power_control_out && !str_valid && !ss_spread_disable)
        else $error("outputs not idle after reset");
    spread_strap_a: assert property ($fell(srst) &&
        $stable(serial_clock_strap_pin) ##1
        ($stable(serial_clock_strap_pin) && !cfg_wr) [*3]
        |-> ss_spread_disable == serial_clock_strap_pin)
        else $error("spread bit not loaded from strap");
    rvalid_cause_a: assert property (cfg_rvalid |->
        $past(cfg_rd) || $past(cfg_rd, 2))
        else $error("read answer without read");
    reserved_zero_a: assert property (cfg_rvalid && $past(cfg_rd) &&
        !$past(cfg_rd, 2) |-> (cfg_rdata & mask) == 8'h00)
        else $error("reserved bits not zero");
    first_byte_a: assert property ($rose(str_valid) |->
        $past(str_req, 4)) else $error("first byte late or early");
    bytes_run_a: assert property (str_valid && !str_last |=>
        str_valid) else $error("gap inside string");
    byte_count_a: assert property (str_last |->
        str_valid && cnt == want - 7'h01) else $error("wrong byte count");
    empty_zero_a: assert property (str_empty |->
        $past(str_req, 2) && want == 7'h00 && !str_valid)
        else $error("empty flag wrong");
    power_drop_a: assert property (charge_mode_change &&
        port_power_control_out |=> !port_power_control_out)
        else $error("power not removed");
    power_time_a: assert property ($rose(port_power_control_out) |->
        off_n == off_want) else $error("power off time wrong");
endmodule // hscfg_asserts
bind hscfg_top hscfg_asserts #(.STEP_CYCLES(STEP_CYCLES)) i_hscfg_asserts (
    .clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .custom_serial_enable(custom_serial_enable),
    .custom_text_enable(custom_text_enable),
    .serial_clock_strap_pin(serial_clock_strap_pin), .str_req(str_req),
    .str_index(str_index), .str_valid(str_valid), .str_last(str_last),
    .str_empty(str_empty), .ss_spread_disable(ss_spread_disable),
    .downstream_custom_charge_enable(downstream_custom_charge_enable),
    .charge_mode_change(charge_mode_change),
    .port_power_control_out(port_power_control_out));

// *** bench/hscfg_top_bench.sv ***
`timescale 1ns/1ps
module hscfg_top_bench;
    logic clk = 1'b0, srst = 1'b1, ser_en = 1'b0, txt_en = 1'b0;
    logic strap = 1'b1, req = 1'b0, dcce = 1'b0, chg = 1'b0;
    logic wr_s, rd_s, rv, sv, sl, se, spread, pwr;
    logic [1:0] idx = 2'h0;
    logic [7:0] addr, wd, rdat, sd, d, em [256];
    logic [7:0] zr [5] = '{8'h23, 8'h24, 8'hf2, 8'h50, 8'h90};
    int n_fail = 0, checked = 0, k, e, n;
    always #12.5 clk = ~clk;
    hscfg_top #(.STEP_CYCLES(4)) i_hscfg_top (.clk(clk), .srst(srst),
        .cfg_wr(wr_s), .cfg_rd(rd_s), .cfg_addr(addr), .cfg_wdata(wd),
        .cfg_rdata(rdat), .cfg_rvalid(rv), .custom_serial_enable(ser_en),
        .custom_text_enable(txt_en), .serial_clock_strap_pin(strap),
        .str_req(req), .str_index(idx), .str_data(sd), .str_valid(sv),
        .str_last(sl), .str_empty(se), .ss_spread_disable(spread),
        .downstream_custom_charge_enable(dcce), .charge_mode_change(chg),
        .port_power_control_out(pwr));
    hscfg_src i_hscfg_src (.clk(clk), .cfg_rdata(rdat), .cfg_rvalid(rv),
        .cfg_wr(wr_s), .cfg_rd(rd_s), .cfg_addr(addr), .cfg_wdata(wd));
    task automatic final_report;
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_hscfg_src.get(a, d);
        check($sformatf("reg %h", a), d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_hscfg_src.put(a, v);
        if (a >= 8'h50 || ser_en) em[a] = v;
    endtask
    task automatic pulse_at(ref logic s);
        @(posedge clk);
        #1;
        s = 1'b1;
        @(posedge clk);
        #1;
        s = 1'b0;
    endtask
    task automatic desc(input logic [1:0] i, input int len, input logic [7:0] b);
        idx = i;
        pulse_at(req);
        k = 0;
        e = 0;
        repeat (len + 4) begin
            @(posedge clk);
            if (sv === 1'b1) begin
                check("string byte", sd, em[b + 8'(k)]);
                check("last flag", {7'h00, sl}, 8'(k == len - 1));
                k++;
            end
            if (se === 1'b1) e++;
        end
        check("byte count", 8'(k), 8'(len));
        check("empty flag", 8'(e), 8'(len == 0));
    endtask
    task automatic power(input int exp);
        pulse_at(chg);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (pwr === 1'b0) n++;
        end
        check("off cycles", 8'(n), 8'(exp));
    endtask
    initial begin
        for (int j = 0; j < 256; j++)
            em[j] = j < 8'h30 || j > 8'h4f ? 8'h00 : 8'h30 + (8'(j) & 8'h09);
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clk);
        check("spread", {7'h00, spread}, 8'h01);
        rd(8'hf0, 8'h01);
        wr(8'hf0, 8'hfe);
        rd(8'hf0, 8'h00);
        check("spread", {7'h00, spread}, 8'h00);
        rd(8'h22, 8'h18);
        rd(8'h3b, 8'h39);
        foreach (zr[j]) rd(zr[j], 8'h00);
        wr(8'h30, 8'ha5);
        rd(8'h30, 8'h30);
        ser_en = 1'b1;
        wr(8'h30, 8'ha5);
        rd(8'h30, 8'ha5);
        wr(8'h22, 8'h03);
        wr(8'h22, 8'h21);
        rd(8'h22, 8'h03);
        wr(8'h23, 8'h04);
        rd(8'h23, 8'h00);
        txt_en = 1'b1;
        wr(8'h23, 8'h41);
        rd(8'h23, 8'h00);
        wr(8'h23, 8'h40);
        rd(8'h23, 8'h40);
        wr(8'h23, 8'h04);
        wr(8'h24, 8'h02);
        wr(8'hf2, 8'hff);
        rd(8'hf2, 8'h0e);
        for (int j = 0; j < 3; j++) begin
            wr(8'h50 + 8'(2 * j), 8'h48 + 8'(j));
            wr(8'h51 + 8'(2 * j), 8'h00);
        end
        wr(8'h90, 8'h50);
        wr(8'h91, 8'h00);
        desc(2'h1, 3, 8'h30);
        desc(2'h3, 4, 8'h50);
        desc(2'h2, 2, 8'h90);
        wr(8'h24, 8'h00);
        desc(2'h2, 0, 8'h90);
        desc(2'h0, 0, 8'h00);
        power(4);
        dcce = 1'b1;
        power(32);
        #1;
        strap = 1'b0;
        srst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clk);
        check("spread", {7'h00, spread}, 8'h00);
        rd(8'h23, 8'h00);
        final_report;
    end
    initial begin
        #200000;
        n_fail++;
        final_report;
    end
endmodule // hscfg_top_bench

// *** common/hscfg_regs.vh ***
`ifndef HSCFG_REGS_VH
`define HSCFG_REGS_VH
`define HSCFG_SER_LEN_OFF 8'h22
`define HSCFG_MAKER_LEN_OFF 8'h23
`define HSCFG_PROD_LEN_OFF 8'h24
`define HSCFG_SER_BASE 8'h30
`define HSCFG_SER_LAST 8'h4f
`define HSCFG_MAKER_BASE 8'h50
`define HSCFG_MAKER_LAST 8'h8f
`define HSCFG_PROD_BASE 8'h90
`define HSCFG_PROD_LAST 8'hcf
`define HSCFG_FEATURE_OFF 8'hf0
`define HSCFG_CHARGE_OFF 8'hf2
`define HSCFG_SER_LEN_RST 6'h18
`define HSCFG_SER_LEN_MAX 7'h20
`define HSCFG_TEXT_LEN_MAX 7'h40
`define HSCFG_SPREAD_BIT 0
`define HSCFG_DELAY_LSB 1
`define HSCFG_DELAY_MSB 3
`define HSCFG_CHARGE_RSVD_BIT 0
`define HSCFG_STEP_MS 200
`define HSCFG_CLK_HZ 40000000
`define HSCFG_STEP_CYCLES (`HSCFG_STEP_MS * (`HSCFG_CLK_HZ / 1000))
`define HSCFG_IDX_SERIAL 2'h1
`define HSCFG_IDX_PRODUCT 2'h2
`define HSCFG_IDX_MAKER 2'h3
`endif

// *** hw/hscfg_mem.v ***
`timescale 1ns/1ps
`include "hscfg_regs.vh"
// byte store with registered read and serial-number default image
module hscfg_mem #(
    parameter AW = 8
) (
    input wire clk,
    input wire srst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:(1<<AW)-1];
    integer i;
    // default image: serial bytes get a fixed pattern, rest zero
    function [7:0] dflt;
        input [AW-1:0] a;
        begin
            if (a >= `HSCFG_SER_BASE && a <= `HSCFG_SER_LAST)
                dflt = 8'h30 + {4'h0, a[3:0] & 4'h9};
            else
                dflt = 8'h00;
        end
    endfunction
    always @(posedge clk) begin
        if (srst) begin
            for (i = 0; i < (1<<AW); i = i + 1)
                mem[i] <= dflt(i[AW-1:0]);
            rd_data <= 8'h00;
        end else begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule // hscfg_mem

// *** hw/hscfg_top.v ***
// Summary of operation
// - string index 1 returns the serial number bytes
// - serial bytes hold a built-in default after reset
// - serial bytes writable only when custom serial enable is set
// - index 3 returns maker length bytes when length is nonzero
// - index 2 returns product length bytes when length is nonzero
// - feature bit 0 set disables spread spectrum of the PLL
// - spread disable bit loads from clock strap pin at reset release
// - delay field applies only while custom charging enable set, else one 200 ms step
// - re-enable delay equals (field plus one) times 200 ms
// - reserved read-only bits read zero, writes ignored, except charge control bit 0, which stores the written bit
// - charge control fields writable by EEPROM or SMBus host
// - serial length defaults to 18h, at most 32 bytes
// - maker length defaults to zero, at most 64 bytes
// - text lengths writable only when custom text enable is set
`timescale 1ns/1ps
`include "hscfg_regs.vh"
module hscfg_top #(
    parameter STEP_CYCLES = `HSCFG_STEP_CYCLES
) (
    input wire clk,
    input wire srst,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    output reg cfg_rvalid,
    input wire custom_serial_enable,
    input wire custom_text_enable,
    input wire serial_clock_strap_pin,
    input wire str_req,
    input wire [1:0] str_index,
    output reg [7:0] str_data,
    output reg str_valid,
    output reg str_last,
    output reg str_empty,
    output reg ss_spread_disable,
    input wire downstream_custom_charge_enable,
    input wire charge_mode_change,
    output reg port_power_control_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SEND = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam PW_ON = 2'h0;
    localparam PW_OFF = 2'h1;

    reg strap_s1, strap_s2;
    reg rst_d;
    reg [5:0] serial_string_length;
    reg [6:0] maker_string_length;
    reg [6:0] product_string_length;
    reg [7:0] extra_feature_config;
    reg [7:0] charge_port_control;
    reg [1:0] state;
    reg [7:0] rd_ptr;
    reg [6:0] remain;
    reg rd_pend;
    reg [1:0] pstate;
    reg [31:0] tick;
    reg [2:0] steps;
    reg mem_rd_pend;
    wire [7:0] mem_q;
    reg mem_we;
    reg [7:0] mem_ra;

    function in_rng;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_rng = (a >= lo) && (a <= hi);
        end
    endfunction

    // serial gate; text bytes always writable
    always @* begin
        mem_we = 1'b0;
        if (cfg_wr) begin
            if (in_rng(cfg_addr, `HSCFG_SER_BASE, `HSCFG_SER_LAST))
                mem_we = custom_serial_enable;
            else if (in_rng(cfg_addr, `HSCFG_MAKER_BASE, `HSCFG_PROD_LAST))
                mem_we = 1'b1;
        end
    end

    // descriptor reads have the memory port while streaming
    always @* begin
        if (state == ST_SEND)
            mem_ra = rd_ptr;
        else
            mem_ra = cfg_addr;
    end

    hscfg_mem #(.AW(8)) i_hscfg_mem (
        .clk(clk),
        .srst(srst),
        .wr_en(mem_we),
        .wr_addr(cfg_addr),
        .wr_data(cfg_wdata),
        .rd_addr(mem_ra),
        .rd_data(mem_q)
    );

    always @(posedge clk) begin
        strap_s1 <= serial_clock_strap_pin;
        strap_s2 <= strap_s1;
    end

    // configuration registers
    always @(posedge clk) begin
        rst_d <= srst;
        if (srst) begin
            serial_string_length <= `HSCFG_SER_LEN_RST;
            maker_string_length <= 7'h00;
            product_string_length <= 7'h00;
            extra_feature_config <= 8'h00;
            charge_port_control <= 8'h00;
        end else begin
            if (rst_d)
                extra_feature_config[`HSCFG_SPREAD_BIT] <= strap_s2;
            if (cfg_wr) begin
                case (cfg_addr)
                    `HSCFG_SER_LEN_OFF:
                        if (custom_serial_enable &&
                            {1'b0, cfg_wdata[5:0]} <= `HSCFG_SER_LEN_MAX)
                            serial_string_length <= cfg_wdata[5:0];
                    `HSCFG_MAKER_LEN_OFF:
                        if (custom_text_enable &&
                            cfg_wdata[6:0] <= `HSCFG_TEXT_LEN_MAX)
                            maker_string_length <= cfg_wdata[6:0];
                    `HSCFG_PROD_LEN_OFF:
                        if (custom_text_enable &&
                            cfg_wdata[6:0] <= `HSCFG_TEXT_LEN_MAX)
                            product_string_length <= cfg_wdata[6:0];
                    `HSCFG_FEATURE_OFF:
                        if (!rst_d)
                            extra_feature_config <= {7'h00, cfg_wdata[0]};
                    `HSCFG_CHARGE_OFF:
                        charge_port_control <= {4'h0, cfg_wdata[3:0]};
                    default: ;
                endcase
            end
        end
    end

    // register read port, one cycle latency for registers, two for memory bytes
    always @(posedge clk) begin
        if (srst) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
            mem_rd_pend <= 1'b0;
        end else begin
            mem_rd_pend <= 1'b0;
            cfg_rvalid <= 1'b0;
            if (mem_rd_pend) begin
                cfg_rdata <= mem_q;
                cfg_rvalid <= 1'b1;
            end
            if (cfg_rd && state != ST_SEND) begin
                if (in_rng(cfg_addr, `HSCFG_SER_BASE, `HSCFG_PROD_LAST)) begin
                    mem_rd_pend <= 1'b1;
                end else begin
                    cfg_rvalid <= 1'b1;
                    case (cfg_addr)
                        `HSCFG_SER_LEN_OFF:
                            cfg_rdata <= {2'h0, serial_string_length};
                        `HSCFG_MAKER_LEN_OFF:
                            cfg_rdata <= {1'b0, maker_string_length};
                        `HSCFG_PROD_LEN_OFF:
                            cfg_rdata <= {1'b0, product_string_length};
                        `HSCFG_FEATURE_OFF:
                            cfg_rdata <= extra_feature_config;
                        `HSCFG_CHARGE_OFF:
                            cfg_rdata <= charge_port_control;
                        default:
                            cfg_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end

    always @(posedge clk) begin
        if (srst)
            ss_spread_disable <= 1'b0;
        else
            ss_spread_disable <= extra_feature_config[`HSCFG_SPREAD_BIT];
    end

    // string descriptor streamer
    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            rd_ptr <= 8'h00;
            remain <= 7'h00;
            rd_pend <= 1'b0;
            str_data <= 8'h00;
            str_valid <= 1'b0;
            str_last <= 1'b0;
            str_empty <= 1'b0;
        end else begin
            str_valid <= 1'b0;
            str_last <= 1'b0;
            str_empty <= 1'b0;
            rd_pend <= 1'b0;
            if (rd_pend) begin
                str_data <= mem_q;
                str_valid <= 1'b1;
                str_last <= (state != ST_SEND);
            end
            case (state)
                ST_IDLE:
                    if (str_req) begin
                        case (str_index)
                            `HSCFG_IDX_SERIAL: begin
                                rd_ptr <= `HSCFG_SER_BASE;
                                remain <= {1'b0, serial_string_length};
                            end
                            `HSCFG_IDX_PRODUCT: begin
                                rd_ptr <= `HSCFG_PROD_BASE;
                                remain <= product_string_length;
                            end
                            `HSCFG_IDX_MAKER: begin
                                rd_ptr <= `HSCFG_MAKER_BASE;
                                remain <= maker_string_length;
                            end
                            default: begin
                                rd_ptr <= 8'h00;
                                remain <= 7'h00;
                            end
                        endcase
                        state <= ST_WAIT;
                    end
                ST_WAIT:
                    if (remain == 7'h00) begin
                        str_empty <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_SEND;
                    end
                ST_SEND: begin
                    rd_pend <= 1'b1;
                    rd_ptr <= rd_ptr + 8'h01;
                    remain <= remain - 7'h01;
                    if (remain == 7'h01)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            pstate <= PW_ON;
            tick <= 32'h0;
            steps <= 3'h0;
            port_power_control_out <= 1'b1;
        end else begin
            case (pstate)
                PW_ON:
                    if (charge_mode_change) begin
                        port_power_control_out <= 1'b0;
                        tick <= 32'h0;
                        steps <= downstream_custom_charge_enable ?
                            charge_port_control[`HSCFG_DELAY_MSB:
                                                `HSCFG_DELAY_LSB] : 3'h0;
                        pstate <= PW_OFF;
                    end
                PW_OFF:
                    if (tick == STEP_CYCLES - 1) begin
                        tick <= 32'h0;
                        if (steps == 3'h0) begin
                            port_power_control_out <= 1'b1;
                            pstate <= PW_ON;
                        end else begin
                            steps <= steps - 3'h1;
                        end
                    end else begin
                        tick <= tick + 32'h1;
                    end
                default:
                    pstate <= PW_ON;
            endcase
        end
    end
endmodule // hscfg_top
